// File: rtl/pvs_map.svh
/*
  Register offsets, field positions, reset values and counts for the transceiver
  vendor status/control and receive error counter bank.
  Assumes inclusion by bare name from the design files.
*/
`ifndef PVS_MAP_SVH
`define PVS_MAP_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------------------
`define PVS_IDX_STATUS_CTRL 6'h10
`define PVS_IDX_SPECIAL_CTRL 6'h11
`define PVS_IDX_STATION_ADDR 6'h12
`define PVS_IDX_FALSE_CARRIER 6'h13
`define PVS_IDX_DISCONNECT 6'h14
`define PVS_IDX_ERROR_FRAME 6'h15
`define PVS_IDX_SYMBOL_ERROR 6'h16
`define PVS_ADDR_LSB 2
`define PVS_ADDR_MSB 7

// ----------------------------------------------------------------------------
// Status and control fields
// ----------------------------------------------------------------------------
`define PVS_SC_CRS_DISC 13
`define PVS_SC_TX_FLOW 12
`define PVS_SC_DESER_SYNC 11
`define PVS_SC_PD_100 10
`define PVS_SC_PD_10 9
`define PVS_SC_POLARITY 8
`define PVS_SC_SPEED 1
`define PVS_SC_DUPLEX 0

// ----------------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------------
`define PVS_SPECIAL_RESET 16'h0000
`define PVS_STATION_ADDR 5'h01
`define PVS_SYM_RUN 3'h6
`define PVS_CNT_ONE 16'h0001
`define PVS_CNT_MAX 16'hffff

`endif

// File: rtl/pvs_pkg.sv
/*
  Types shared by the transceiver vendor register bank.
  Assumes pvs_map.svh is on the include path.
*/
`default_nettype none
package pvs_pkg;
  // Special control word; field order is bit 15 down to bit 0
  typedef struct packed {
    logic scram_bypass;
    logic enc_bypass;
    logic force_h_pattern;
    logic force_34_pattern;
    logic force_link_good;
    logic rsvd10;
    logic tx_crs_disable;
    logic dyn_pd_disable;
    logic an_loopback;
    logic tx_tristate;
    logic filter_bypass;
    logic auto_pol_disable;
    logic squelch_disable;
    logic ext_squelch;
    logic link_int_disable;
    logic jabber_disable;
  } pvs_special_s;

  // Live status from the transceiver core
  typedef struct packed {
    logic deser_sync;
    logic pd_100;
    logic pd_10;
    logic pol_reversed;
    logic speed_100;
    logic full_duplex;
  } pvs_status_s;

  // Receive error events, one-cycle pulses
  typedef struct packed {
    logic false_carrier;
    logic disconnect;
    logic frame_error;
    logic frame_end;
    logic symbol_error;
  } pvs_events_s;
endpackage
`default_nettype wire

// File: rtl/pvs_sat_counter.sv
/*
  Saturating 16-bit event counter that clears when read.
  Assumes inc and clr come from logic on the same clock.
*/
`default_nettype none
`include "pvs_map.svh"
module pvs_sat_counter #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic inc,
  input wire logic clr,
  // Value
  output logic [WIDTH-1:0] count_q
);
  // The one and full-scale constants are 16 bits wide
  if (WIDTH != 16)
  begin : g_width_check
    $error("pvs_sat_counter supports WIDTH 16 only");
  end

  // An event in the read cycle lands after the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_q <= '0;
    end
    else if (clr)
    begin
      count_q <= inc ? `PVS_CNT_ONE : '0;
    end
    else if (inc && count_q != `PVS_CNT_MAX)
    begin
      count_q <= count_q + `PVS_CNT_ONE;
    end
  end

  a_count_sat: assert property (@(posedge pclk) disable iff (!presetn)
    (count_q == `PVS_CNT_MAX && !clr) |=> count_q == `PVS_CNT_MAX)
    else $error("counter wrapped");
  a_clear_read: assert property (@(posedge pclk) disable iff (!presetn)
    clr |=> count_q == {15'h0000, $past(inc)})
    else $error("read clear wrong");
endmodule
`default_nettype wire

// File: rtl/pvs_regs.sv
/*
  APB register bank: status/control, special test control, station address
  and four clear-on-read receive error counters.
  Assumes status and event inputs are on pclk except status pins, which are
  synchronised here; the APB master follows the standard protocol.
*/
`default_nettype none
`include "pvs_map.svh"

// Behaviour
// - Status bit 13 enables carrier-sense disconnect
// - Status bit 12 one turns flow control on
// - Bit 11 shows deserializer in sync
// - Bits 10,9 show power-down, reset one
// - Bit 8 shows reversed 10 Mbps polarity
// - Bits 1,0 show speed and duplex
// - Special bit 15 bypasses scrambler, resets zero
// - Special bit 14 bypasses 4B/5B encoding
// - Bits 13,12 force H and 34 patterns
// - Bit 11 forces 100 Mbps link good
// - Bit 9 disables transmit carrier sense
// - Bit 8 disables dynamic power-down
// - Bit 7 selects auto-negotiation loopback
// - Bit 6 tri-states the line driver
// - Bit 5 filter bypass, bit 4 polarity-correction off
// - Bit 3 squelch test off, bit 2 extended
// - Bit 1 link integrity off, bit 0 jabber
// - Address register reads fixed 00001b
// - False-carrier counter clears on read
// - Disconnect counter saturates, clears on read
// - Error frames counted once per frame
// - Six-symbol runs count as one error
module pvs_regs (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transceiver status, asynchronous
  input wire pvs_pkg::pvs_status_s status_async,
  // Receive events, pclk pulses
  input wire pvs_pkg::pvs_events_s events,
  // Controls to the transceiver core
  output logic crs_disconnect_en,
  output logic tx_flow_ctrl_en,
  output pvs_pkg::pvs_special_s special_q
);
  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  logic [5:0] idx;
  logic hit;
  logic setup;
  logic rd_stb;
  logic wr_stb;
  assign idx = paddr[`PVS_ADDR_MSB:`PVS_ADDR_LSB];
  assign hit = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'b00) &&
               (idx >= `PVS_IDX_STATUS_CTRL) && (idx <= `PVS_IDX_SYMBOL_ERROR);
  assign setup = psel && !penable;
  // Answer comes one cycle after the access phase starts, so the strobes
  // fire on the edge at which the master samples pready high
  assign rd_stb = psel && penable && pready && !pwrite && hit;
  assign wr_stb = psel && penable && pready && pwrite && hit;

  // --------------------------------------------------------------------------
  // Status synchroniser
  // --------------------------------------------------------------------------
  pvs_pkg::pvs_status_s sync1_q;
  pvs_pkg::pvs_status_s stat_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= 6'b011000;
      stat_q <= 6'b011000;
    end
    else
    begin
      sync1_q <= status_async;
      stat_q <= sync1_q;
    end
  end

  // --------------------------------------------------------------------------
  // Writable registers
  // --------------------------------------------------------------------------
  logic [1:0] sc_rsvd_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      crs_disconnect_en <= 1'b0;
      tx_flow_ctrl_en <= 1'b0;
      sc_rsvd_q <= 2'b00;
    end
    else if (wr_stb && idx == `PVS_IDX_STATUS_CTRL)
    begin
      crs_disconnect_en <= pwdata[`PVS_SC_CRS_DISC];
      tx_flow_ctrl_en <= pwdata[`PVS_SC_TX_FLOW];
      sc_rsvd_q <= pwdata[15:14];
    end
  end

  // Every bit except reserved bit 10 drives one test switch in the core
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      special_q <= `PVS_SPECIAL_RESET;
    end
    else if (wr_stb && idx == `PVS_IDX_SPECIAL_CTRL)
    begin
      special_q <= pwdata[15:0];
    end
  end

  // --------------------------------------------------------------------------
  // Event qualification
  // --------------------------------------------------------------------------
  logic frame_flagged_q;
  logic [2:0] sym_run_q;
  logic frame_inc;
  logic sym_inc;
  // First error of a frame counts; frame_end re-arms
  assign frame_inc = events.frame_error && !frame_flagged_q;
  // Count on the first bad symbol of each run of six
  assign sym_inc = events.symbol_error && sym_run_q == 3'h0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      frame_flagged_q <= 1'b0;
    end
    else if (events.frame_end)
    begin
      frame_flagged_q <= 1'b0;
    end
    else if (events.frame_error)
    begin
      frame_flagged_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sym_run_q <= 3'h0;
    end
    else if (events.frame_end)
    begin
      sym_run_q <= 3'h0;
    end
    else if (events.symbol_error)
    begin
      sym_run_q <= (sym_run_q == `PVS_SYM_RUN - 3'h1) ? 3'h0 : sym_run_q + 3'h1;
    end
  end

  // --------------------------------------------------------------------------
  // Counters
  // --------------------------------------------------------------------------
  localparam int NCNT = 4;
  logic [NCNT-1:0] cnt_inc;
  logic [NCNT-1:0] cnt_clr;
  logic [15:0] cnt_val [NCNT];
  assign cnt_inc = {sym_inc, frame_inc, events.disconnect, events.false_carrier};

  genvar g;
  generate
    for (g = 0; g < NCNT; g++)
    begin : g_cnt
      assign cnt_clr[g] = rd_stb && (idx == `PVS_IDX_FALSE_CARRIER + 6'(g));
      pvs_sat_counter #(.WIDTH(16)) u_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .inc(cnt_inc[g]),
        .clr(cnt_clr[g]),
        .count_q(cnt_val[g])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Read mux and APB answer
  // --------------------------------------------------------------------------
  logic [15:0] rd_word;
  always_comb
  begin
    rd_word = 16'h0000;
    unique case (idx)
      `PVS_IDX_STATUS_CTRL:
      begin
        rd_word[15:14] = sc_rsvd_q;
        rd_word[`PVS_SC_CRS_DISC] = crs_disconnect_en;
        rd_word[`PVS_SC_TX_FLOW] = tx_flow_ctrl_en;
        rd_word[`PVS_SC_DESER_SYNC] = stat_q.deser_sync;
        rd_word[`PVS_SC_PD_100] = stat_q.pd_100;
        rd_word[`PVS_SC_PD_10] = stat_q.pd_10;
        rd_word[`PVS_SC_POLARITY] = stat_q.pol_reversed;
        rd_word[`PVS_SC_SPEED] = stat_q.speed_100;
        rd_word[`PVS_SC_DUPLEX] = stat_q.full_duplex;
      end
      `PVS_IDX_SPECIAL_CTRL: rd_word = special_q;
      `PVS_IDX_STATION_ADDR: rd_word = {11'h000, `PVS_STATION_ADDR};
      `PVS_IDX_FALSE_CARRIER: rd_word = cnt_val[0];
      `PVS_IDX_DISCONNECT: rd_word = cnt_val[1];
      `PVS_IDX_ERROR_FRAME: rd_word = cnt_val[2];
      `PVS_IDX_SYMBOL_ERROR: rd_word = cnt_val[3];
      default: rd_word = 16'h0000;
    endcase
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && penable && !pready)
    begin
      pready <= 1'b1;
      pslverr <= !hit;
      // Counter value captured before the clear edge
      prdata <= (hit && !pwrite) ? {16'h0000, rd_word} : 32'h0000_0000;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_addr_fixed: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && psel && !pwrite && idx == `PVS_IDX_STATION_ADDR && hit)
      |-> prdata == 32'h0000_0001)
    else $error("station address wrong");
  a_special_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_stb && idx == `PVS_IDX_SPECIAL_CTRL) |=> special_q == $past(pwdata[15:0]))
    else $error("special control not written");
  a_flow_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_stb && idx == `PVS_IDX_STATUS_CTRL)
      |=> tx_flow_ctrl_en == $past(pwdata[12]) && crs_disconnect_en == $past(pwdata[13]))
    else $error("status control not written");
  a_status_pipe: assert property (@(posedge pclk) disable iff (!presetn)
    ##2 stat_q == $past(status_async, 2))
    else $error("status sync wrong");
  a_frame_once: assert property (@(posedge pclk) disable iff (!presetn)
    (frame_inc && !events.frame_end) |=> !frame_inc)
    else $error("frame counted twice");
  a_sym_run: assert property (@(posedge pclk) disable iff (!presetn)
    (sym_inc && !events.frame_end) ##1 (events.symbol_error && !events.frame_end)[*5]
      |-> !sym_inc)
    else $error("symbol run miscounted");
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready held");
  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !hit) ##1 (psel && penable && !hit) |=> pslverr)
    else $error("unmapped not refused");

  c_counter_read: cover property (@(posedge pclk) disable iff (!presetn) cnt_clr[1]);
  c_read_with_event: cover property (@(posedge pclk) disable iff (!presetn)
    cnt_clr[0] && cnt_inc[0]);
  c_special_write: cover property (@(posedge pclk) disable iff (!presetn)
    wr_stb && idx == `PVS_IDX_SPECIAL_CTRL);
  c_sym_six: cover property (@(posedge pclk) disable iff (!presetn)
    events.symbol_error[*6]);
endmodule
`default_nettype wire

// File: test/pvs_core_model.sv
/*
  Behavioural model of the transceiver core beside the register bank:
  drives the live status levels and the one-cycle receive event pulses.
  Assumes the bench calls its tasks right after a rising pclk edge.
*/
`default_nettype none
module pvs_core_model (
  // Clock
  input wire logic pclk,
  // Core side of the bank
  output var pvs_pkg::pvs_status_s status_async,
  output var pvs_pkg::pvs_events_s events
);
  timeunit 1ns;
  timeprecision 1ps;

  // --------------------------------------------------------------------------
  // Drive
  // --------------------------------------------------------------------------
  // Both power-down flags up, as the core leaves reset powered down
  initial
  begin
    status_async = 6'b01_1000;
    events = 5'b0_0000;
  end

  // Hold an event set for n edges; back-to-back edges mean back-to-back events
  task automatic pulse(input pvs_pkg::pvs_events_s e, input int n);
    events <= e;
    repeat (n) @(posedge pclk);
    events <= 5'b0_0000;
    // Let an edge pass so a following pulse never re-drives events in one step
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// File: test/pvs_regs_tb_top.sv
/*
  Self-checking bench for the vendor register bank over APB.
  Assumes pvs_pkg and the core model are compiled first.
*/
`default_nettype none
module pvs_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic crs;
  logic flow;
  pvs_pkg::pvs_special_s special_q;
  pvs_pkg::pvs_status_s st;
  pvs_pkg::pvs_events_s ev;
  int bad_count = 0;
  int num_checks = 0;

  always #4 pclk = ~pclk;

  pvs_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .status_async(st), .events(ev), .crs_disconnect_en(crs),
    .tx_flow_ctrl_en(flow), .special_q(special_q));
  pvs_core_model model_u (.pclk(pclk), .status_async(st), .events(ev));

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Starts one edge in so a release and a new setup never share a time step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic ev_on, output logic [31:0] r, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Request holds until pready is sampled high at a rising edge
    do
    begin
      @(posedge pclk);
      n++;
      // With one wait state an event forked here lands on the clearing edge
      if (ev_on && n == 1 && pready !== 1'b1)
      begin
        fork
          model_u.pulse(5'b1_0000, 1);
        join_none
      end
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      bad_count++;
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, 1'b0, r, e);
    cmp(r, exp);
    cmp({31'h0, e}, {31'h0, ee});
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, 1'b0, r, e);
    cmp({31'h0, e}, {31'h0, ee});
    // The write lands on the sampling edge; look once it has settled
    @(negedge pclk);
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset();
    rd(12'h040, 32'h0000_0600, 1'b0);
    cmp({16'h0, special_q}, 32'h0000_0000);
    rd(12'h048, 32'h0000_0001, 1'b0);
    for (int i = 0; i < 4; i++)
      rd(12'h04C + 12'(4 * i), 32'h0000_0000, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_status();
    model_u.status_async <= 6'b11_0101;
    repeat (3) @(posedge pclk);
    wr(12'h040, 32'h0000_ffff, 1'b0);
    cmp({30'h0, crs, flow}, 32'h0000_0003);
    rd(12'h040, 32'h0000_fd01, 1'b0);
    model_u.status_async <= 6'b00_1010;
    wr(12'h040, 32'h0000_1000, 1'b0);
    cmp({30'h0, crs, flow}, 32'h0000_0001);
    rd(12'h040, 32'h0000_1202, 1'b0);
    $display("test status done");
  endtask

  task automatic t_special();
    logic [31:0] v;
    for (int i = 0; i < 16; i++)
    begin
      v = 32'h0000_0001 << i;
      wr(12'h044, v, 1'b0);
      cmp({16'h0, special_q}, v);
      rd(12'h044, v, 1'b0);
    end
    wr(12'h044, 32'h0000_0000, 1'b0);
    $display("test special done");
  endtask

  // Read-only writes are dropped quietly; bad addresses answer with an error
  task automatic t_refuse();
    wr(12'h048, 32'h0000_ffff, 1'b0);
    rd(12'h048, 32'h0000_0001, 1'b0);
    wr(12'h045, 32'h0000_ffff, 1'b1);
    wr(12'h144, 32'h0000_ffff, 1'b1);
    rd(12'h05C, 32'h0000_0000, 1'b1);
    cmp({16'h0, special_q}, 32'h0000_0000);
    $display("test refuse done");
  endtask

  task automatic t_count();
    model_u.pulse(5'b1_0000, 3);
    rd(12'h04C, 32'h0000_0003, 1'b0);
    rd(12'h04C, 32'h0000_0000, 1'b0);
    model_u.pulse(5'b0_1000, 65537);
    rd(12'h050, 32'h0000_ffff, 1'b0);
    rd(12'h050, 32'h0000_0000, 1'b0);
    model_u.pulse(5'b0_0100, 3);
    model_u.pulse(5'b0_0010, 1);
    rd(12'h054, 32'h0000_0001, 1'b0);
    model_u.pulse(5'b0_0001, 13);
    model_u.pulse(5'b0_0010, 1);
    rd(12'h058, 32'h0000_0003, 1'b0);
    $display("test counters done");
  endtask

  task automatic t_coinc();
    logic [31:0] r;
    logic e;
    model_u.pulse(5'b1_0000, 2);
    apb(1'b0, 12'h04C, 32'h0000_0000, 1'b1, r, e);
    cmp(r, 32'h0000_0002);
    rd(12'h04C, 32'h0000_0001, 1'b0);
    $display("test coincident done");
  endtask

  // --------------------------------------------------------------------------
  // Run control
  // --------------------------------------------------------------------------
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Saturation test dominates at about 66k cycles; the limit stays under 90k
  initial
  begin
    #700_000;
    bad_count++;
    conclude();
  end

  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_status();
    t_special();
    t_refuse();
    t_count();
    t_coinc();
    conclude();
  end
endmodule
`default_nettype wire
